// file: include/fsp_defines.svh
// Constants of the flash self-programming controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design and the bench.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define FSP_CSR_IDX      8'h37
`define FSP_CSR_ADDR     ({`FSP_CSR_IDX, 2'b00})
`define FSP_CSR_RESET    8'h00

// -----------------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------------
`define FSP_BIT_PERMIT   0
`define FSP_BIT_ERASE    1
`define FSP_BIT_WRITE    2
`define FSP_BIT_FUSE     3
`define FSP_BIT_CLRBUF   4
`define FSP_BIT_SIG      5

// -----------------------------------------------------------------------------
// Pointer values for fuse and lock reads
// -----------------------------------------------------------------------------
`define FSP_Z_FUSE_LOW   16'h0000
`define FSP_Z_LOCK       16'h0001
`define FSP_Z_FUSE_EXT   16'h0002
`define FSP_Z_FUSE_HIGH  16'h0003

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define FSP_WIN_STORE    3'h4
`define FSP_WIN_LOAD     3'h3
`define FSP_CLK_NS       20
`define FSP_OP_MIN_NS    3700000
`define FSP_OP_MAX_NS    4500000
`define FSP_RC_DIV       50
`define FSP_OP_TICKS     ((`FSP_OP_MIN_NS + `FSP_CLK_NS * `FSP_RC_DIV - 1) \
                          / (`FSP_CLK_NS * `FSP_RC_DIV))

`endif

// file: include/fsp_pkg.sv
// Types of the flash self-programming controller.
// Assumes fsp_defines.svh on the include path.
package fsp_pkg;

   // CPU instruction strobes with pointer and data pair
   typedef struct packed {
      logic        load;
      logic        store;
      logic [15:0] zptr;
      logic [15:0] data;
   } fsp_instr_type;

   // Stored fuse and lock bytes, 1 = unprogrammed
   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic [7:0] ext;
      logic [7:0] lock;
   } fsp_fuse_type;

   // Timed flash array operation
   typedef struct packed {
      logic        erase;
      logic        write;
      logic [14:0] word_addr;
   } fsp_flash_type;

   // Temporary page buffer access
   typedef struct packed {
      logic        wr;
      logic        clear;
      logic [14:0] word_addr;
      logic [15:0] data;
   } fsp_pbuf_type;

   typedef enum logic [1:0] {
      FSP_OP_IDLE = 2'b00,
      FSP_OP_RUN  = 2'b01,
      FSP_OP_DONE = 2'b11
   } fsp_op_state_type;

endpackage

// file: design/fsp_selfprog_ctrl.sv
// Flash self-programming controller: control register, timed enables, fuse/lock/signature
// reads, page buffer loads, page erase and page write with CPU stall.
// Assumes an APB master, a CPU core giving one-cycle load/store strobes, and a flash
// array that acts on its request levels. porn_i is power-on reset only.
`timescale 1ns/100ps
`include "fsp_defines.svh"

module fsp_selfprog_ctrl #(
   parameter int          OP_TICKS  = `FSP_OP_TICKS,
   parameter int          RC_DIV    = `FSP_RC_DIV,
   parameter logic [31:0] SIG_TABLE = 32'h5a_a5_3c_c3  // Arbitrary identity values
) (
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   input  wire logic                   porn_i,
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [9:0]             paddr_i,
   input  wire logic [31:0]            pwdata_i,
   output logic      [31:0]            prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   input  wire fsp_pkg::fsp_instr_type instr_i,
   input  wire fsp_pkg::fsp_fuse_type  fuse_i,
   input  wire logic                   eeprom_busy_i,
   output logic      [7:0]             load_data_o,
   output logic                        load_special_o,
   output logic                        cpu_stall_o,
   output fsp_pkg::fsp_flash_type      flash_o,
   output fsp_pkg::fsp_pbuf_type       pbuf_o
);
   import fsp_pkg::*;

   // --------------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------------
   logic             permit_q;
   logic             erase_q;
   logic             write_q;
   logic             fuse_rd_q;
   logic             clrbuf_q;
   logic             sig_q;
   logic [2:0]       win_q;
   logic             busy;
   logic             busy_write;
   logic             csr_hit;
   logic             apb_acc;
   logic             csr_wr;
   logic             win_end;
   logic             fuse_mode;
   logic             load_fuse;
   logic             load_sig;
   logic             store_ok;
   logic             op_start;
   logic             self_permit;
   logic [7:0]       csr_rd;
   logic [7:0]       fuse_sel;
   logic [7:0]       sig_sel;
   fsp_op_state_type op_q;
   logic             op_write_q;
   logic [15:0]      tick_cnt_q;
   logic [15:0]      div_q;
   logic             rc_tick_q;

   // --------------------------------------------------------------------------
   // Decode
   // --------------------------------------------------------------------------
   assign busy        = (op_q != FSP_OP_IDLE);
   assign busy_write  = busy && op_write_q;
   assign csr_hit     = (paddr_i == `FSP_CSR_ADDR);
   assign apb_acc     = psel_i && penable_i && !pready_o;
   assign csr_wr      = apb_acc && pwrite_i && csr_hit && !busy && !eeprom_busy_i;
   assign win_end     = (win_q == 3'h1);
   assign self_permit = !fuse_i.ext[0];
   assign fuse_mode   = permit_q && fuse_rd_q && (win_q != 3'h0) && !eeprom_busy_i;
   assign load_fuse   = instr_i.load && fuse_mode;
   assign load_sig    = instr_i.load && permit_q && sig_q && (win_q != 3'h0);
   assign store_ok    = instr_i.store && permit_q && (win_q != 3'h0) && !fuse_rd_q && !sig_q
                        && self_permit && !busy && !eeprom_busy_i;
   assign op_start    = store_ok && (erase_q || write_q);

   // Reserved bits 7:6 are wired to zero
   assign csr_rd = {2'b00, sig_q, clrbuf_q, fuse_rd_q,
                    write_q || busy_write, erase_q || (busy && !op_write_q),
                    permit_q || busy};

   // Stored bits are 0 when programmed and pass unchanged
   always_comb begin
      unique case (instr_i.zptr)
         `FSP_Z_LOCK:      fuse_sel = fuse_i.lock;
         `FSP_Z_FUSE_EXT:  fuse_sel = fuse_i.ext;
         `FSP_Z_FUSE_HIGH: fuse_sel = fuse_i.high;
         default:          fuse_sel = instr_i.zptr[0] ? fuse_i.lock : fuse_i.low;
      endcase
   end

   always_comb begin
      sig_sel = 8'hff;
      if (instr_i.zptr[15:2] == 14'h0000) begin
         sig_sel = SIG_TABLE[{instr_i.zptr[1:0], 3'b000} +: 8];
      end
   end

   // --------------------------------------------------------------------------
   // APB slave, one wait state
   // --------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= apb_acc;
         pslverr_o <= apb_acc && !csr_hit;
         if (apb_acc && !pwrite_i) begin
            prdata_o <= csr_hit ? {24'h00_0000, csr_rd} : 32'h0000_0000;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Control register and command window
   // --------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         {sig_q, clrbuf_q, fuse_rd_q, write_q, erase_q, permit_q} <= 6'(`FSP_CSR_RESET);
         win_q <= 3'h0;
      end else if (csr_wr) begin
         permit_q  <= pwdata_i[`FSP_BIT_PERMIT];
         erase_q   <= pwdata_i[`FSP_BIT_ERASE];
         write_q   <= pwdata_i[`FSP_BIT_WRITE];
         fuse_rd_q <= pwdata_i[`FSP_BIT_FUSE];
         clrbuf_q  <= pwdata_i[`FSP_BIT_CLRBUF];
         sig_q     <= pwdata_i[`FSP_BIT_SIG];
         if (!pwdata_i[`FSP_BIT_PERMIT]) begin
            win_q <= 3'h0;
         end else if (pwdata_i[`FSP_BIT_FUSE] || pwdata_i[`FSP_BIT_SIG]) begin
            win_q <= `FSP_WIN_LOAD;
         end else begin
            win_q <= `FSP_WIN_STORE;
         end
      end else if (load_fuse || store_ok || (win_end && !busy)) begin
         // Done or timed out; a running operation shows through busy
         {sig_q, clrbuf_q, fuse_rd_q, write_q, erase_q, permit_q} <= 6'(`FSP_CSR_RESET);
         win_q <= 3'h0;
      end else if (win_q != 3'h0) begin
         win_q <= win_q - 3'h1;
      end
   end

   // --------------------------------------------------------------------------
   // Special load answers
   // --------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         load_data_o    <= 8'h00;
         load_special_o <= 1'b0;
      end else begin
         load_special_o <= load_fuse || load_sig;
         if (load_fuse) begin
            load_data_o <= fuse_sel;
         end else if (load_sig) begin
            load_data_o <= sig_sel;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Temporary page buffer; cleared at reset, on the clear-buffer bit and after a page write
   // --------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pbuf_o <= '{wr: 1'b0, clear: 1'b1, word_addr: 15'h0000, data: 16'h0000};
      end else begin
         pbuf_o.wr    <= store_ok && !erase_q && !write_q;
         pbuf_o.clear <= (csr_wr && pwdata_i[`FSP_BIT_CLRBUF])
                         || ((op_q == FSP_OP_DONE) && op_write_q);
         if (store_ok) begin
            pbuf_o.word_addr <= instr_i.zptr[15:1];
            pbuf_o.data      <= instr_i.data;
         end
      end
   end

   // --------------------------------------------------------------------------
   // Oscillator tick divider
   // --------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge porn_i) begin
      if (!porn_i) begin
         div_q     <= 16'h0000;
         rc_tick_q <= 1'b0;
      end else begin
         rc_tick_q <= (div_q == 16'h0000);
         div_q     <= (div_q == 16'h0000) ? 16'(RC_DIV - 1) : div_q - 16'h0001;
      end
   end

   // --------------------------------------------------------------------------
   // Flash operation engine, untouched by system reset
   // --------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge porn_i) begin
      if (!porn_i) begin
         op_q        <= FSP_OP_IDLE;
         op_write_q  <= 1'b0;
         tick_cnt_q  <= 16'h0000;
         cpu_stall_o <= 1'b0;
         flash_o     <= '{erase: 1'b0, write: 1'b0, word_addr: 15'h0000};
      end else begin
         unique case (op_q)
            FSP_OP_IDLE: begin
               if (op_start) begin
                  op_q              <= FSP_OP_RUN;
                  op_write_q        <= write_q;
                  tick_cnt_q        <= 16'(OP_TICKS);
                  cpu_stall_o       <= 1'b1;
                  flash_o.erase     <= erase_q && !write_q;
                  flash_o.write     <= write_q;
                  flash_o.word_addr <= instr_i.zptr[15:1];
               end
            end
            FSP_OP_RUN: begin
               if (rc_tick_q) begin
                  tick_cnt_q <= tick_cnt_q - 16'h0001;
                  if (tick_cnt_q == 16'h0001) begin
                     op_q          <= FSP_OP_DONE;
                     flash_o.erase <= 1'b0;
                     flash_o.write <= 1'b0;
                  end
               end
            end
            FSP_OP_DONE: begin
               op_q        <= FSP_OP_IDLE;
               cpu_stall_o <= 1'b0;
            end
            default: begin
               op_q        <= FSP_OP_IDLE;
               cpu_stall_o <= 1'b0;
            end
         endcase
      end
   end

   // --------------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i || !porn_i);

   property p_rsvd_zero;
      pready_o && !pwrite_i && csr_hit |-> prdata_o[7:6] == 2'b00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

   property p_lock_read;
      load_fuse && instr_i.zptr == `FSP_Z_LOCK
         |=> load_special_o && load_data_o == $past(fuse_i.lock);
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

   property p_fuse_low;
      load_fuse && instr_i.zptr == `FSP_Z_FUSE_LOW |=> load_data_o == $past(fuse_i.low);
   endproperty
   a_fuse_low: assert property (p_fuse_low) else $error("fuse low read wrong");

   property p_fuse_high;
      load_fuse && instr_i.zptr == `FSP_Z_FUSE_HIGH |=> load_data_o == $past(fuse_i.high);
   endproperty
   a_fuse_high: assert property (p_fuse_high) else $error("fuse high read wrong");

   property p_fuse_ext;
      load_fuse && instr_i.zptr == `FSP_Z_FUSE_EXT |=> load_data_o == $past(fuse_i.ext);
   endproperty
   a_fuse_ext: assert property (p_fuse_ext) else $error("fuse ext read wrong");

   property p_fuse_clear;
      load_fuse |=> !fuse_rd_q && !permit_q;
   endproperty
   a_fuse_clear: assert property (p_fuse_clear) else $error("fuse read bits stuck");

   property p_sig_clear;
      csr_wr && pwdata_i[`FSP_BIT_SIG] && pwdata_i[`FSP_BIT_PERMIT] && !pwdata_i[`FSP_BIT_FUSE]
         |=> sig_q[*3] ##1 !sig_q && !permit_q;
   endproperty
   a_sig_clear: assert property (p_sig_clear) else $error("signature bits timing wrong");

   property p_store_timeout;
      win_end && !busy && !instr_i.store && !instr_i.load && !csr_wr |=> !write_q && !erase_q;
   endproperty
   a_store_timeout: assert property (p_store_timeout) else $error("command bit not cleared");

   property p_stall;
      op_start |=> cpu_stall_o && (flash_o.write == $past(write_q)) && busy;
   endproperty
   a_stall: assert property (p_stall) else $error("no stall on operation");

   property p_ignore_busy;
      busy && psel_i && penable_i && pwrite_i |=> $stable({sig_q, fuse_rd_q, write_q, erase_q});
   endproperty
   a_ignore_busy: assert property (p_ignore_busy) else $error("write taken while busy");

   property p_eeprom_block;
      eeprom_busy_i && instr_i.load && !sig_q |=> !load_special_o;
   endproperty
   a_eeprom_block: assert property (p_eeprom_block) else $error("read during eeprom write");

   property p_sig_read;
      load_sig && instr_i.zptr == 16'h0001 |=> load_special_o && load_data_o == SIG_TABLE[15:8];
   endproperty
   a_sig_read: assert property (p_sig_read) else $error("signature read wrong");

   property p_ptr_bit_zero;
      load_fuse && instr_i.zptr[15:2] != 14'h0000
         |=> load_data_o == ($past(instr_i.zptr[0]) ? $past(fuse_i.lock) : $past(fuse_i.low));
   endproperty
   a_ptr_bit_zero: assert property (p_ptr_bit_zero) else $error("bit zero ignored");

   property p_clrbuf;
      csr_wr && pwdata_i[`FSP_BIT_CLRBUF] |=> pbuf_o.clear;
   endproperty
   a_clrbuf: assert property (p_clrbuf) else $error("page buffer not cleared");

   property p_buf_store;
      store_ok && !erase_q && !write_q
         |=> pbuf_o.wr && pbuf_o.data == $past(instr_i.data)
             && pbuf_o.word_addr == $past(instr_i.zptr[15:1]);
   endproperty
   a_buf_store: assert property (p_buf_store) else $error("buffer store wrong");

   property p_op_addr;
      op_start |=> flash_o.word_addr == $past(instr_i.zptr[15:1])
                   && (flash_o.erase || flash_o.write);
   endproperty
   a_op_addr: assert property (p_op_addr) else $error("page address wrong");

   property p_keep_op;
      disable iff (!porn_i)
      busy && !resetn_i && tick_cnt_q > 16'h0002 |=> busy && cpu_stall_o;
   endproperty
   a_keep_op: assert property (p_keep_op) else $error("op aborted");

   property p_write_clear;
      $fell(flash_o.write) |=> pbuf_o.clear;
   endproperty
   a_write_clear: assert property (p_write_clear) else $error("buffer kept after write");

   c_erase: cover property (op_start && erase_q);
   c_write: cover property (op_start && write_q);
   c_fuse:  cover property (load_fuse);
   c_sig:   cover property (load_sig);
   c_clrbuf: cover property (csr_wr && pwdata_i[`FSP_BIT_CLRBUF]);

endmodule // fsp_selfprog_ctrl

// file: verif/fsp_cpu_model.sv
// CPU core model: one-cycle load and store strobes with pointer and data pair.
// Assumes the controller's instruction port and answer outputs, system clock only.
`timescale 1ns/100ps

module fsp_cpu_model (
   input  wire logic              clk_i,
   input  wire logic              cpu_stall_i,
   input  wire logic [7:0]        load_data_i,
   input  wire logic              load_special_i,
   output fsp_pkg::fsp_instr_type instr_o
);
   import fsp_pkg::*;

   initial instr_o = '0;

   // ---------------------------------------------------------------------------
   // Instruction issue, entered just after a rising edge
   // ---------------------------------------------------------------------------
   task automatic issue(input logic is_load, input logic [15:0] zptr, input logic [15:0] data,
                        input int dly, output logic special, output logic [7:0] result);
      repeat (dly) @(posedge clk_i);
      while (cpu_stall_i !== 1'b0) @(posedge clk_i);
      instr_o.load  <= is_load;
      instr_o.store <= ~is_load;
      instr_o.zptr  <= zptr;
      instr_o.data  <= data;
      @(posedge clk_i);
      instr_o.load  <= 1'b0;
      instr_o.store <= 1'b0;
      // Released pointer and data scrambled
      instr_o.zptr  <= ~zptr;
      instr_o.data  <= ~data;
      @(posedge clk_i);
      special = load_special_i;
      result  = load_data_i;
      repeat (3) @(posedge clk_i);
   endtask
endmodule // fsp_cpu_model

// file: verif/flash_selfprog_control_bench.sv
// Self-checking bench of the flash self-programming controller.
// Assumes fsp_pkg, fsp_defines.svh and the CPU core model; APB master in this file.
`timescale 1ns/100ps
`include "fsp_defines.svh"

module flash_selfprog_control_bench;
   import fsp_pkg::*;

   localparam int           OP_TICKS_C = 20;
   localparam int           RC_DIV_C   = 2;
   localparam int           OP_CYC_C   = OP_TICKS_C * RC_DIV_C;
   localparam logic [31:0]  SIG_C      = 32'h1122_3344; // Arbitrary value
   localparam logic [9:0]   CSR_A      = `FSP_CSR_ADDR;
   localparam fsp_fuse_type FUSE_C     = {8'h62, 8'hdf, 8'hfe, 8'hfc};

   typedef struct {
      logic [7:0]  csr;
      logic [15:0] z;
      int          dly;
      logic        spec;
      logic [7:0]  dat;
   } fsp_row_type;

   logic          clk = 1'b0;
   logic          resetn = 1'b0;
   logic          porn = 1'b0;
   logic          psel = 1'b0;
   logic          penable = 1'b0;
   logic          pwrite = 1'b0;
   logic          eeprom_busy = 1'b0;
   logic [9:0]    paddr = '0;
   logic [31:0]   pwdata = '0;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   fsp_instr_type instr;
   fsp_fuse_type  fuse = FUSE_C;
   logic [7:0]    load_data;
   logic          load_special;
   logic          cpu_stall;
   fsp_flash_type flash;
   fsp_flash_type flash_seen;
   fsp_pbuf_type  pbuf;
   fsp_pbuf_type  pbuf_seen;
   int            n_errors = 0;
   int            cmp_count = 0;
   int            wr_cnt = 0;
   int            clr_cnt = 0;
   int            stall_cnt = 0;
   time           last_end = 0;
   fsp_row_type   rows [14];

   fsp_selfprog_ctrl #(.OP_TICKS(OP_TICKS_C), .RC_DIV(RC_DIV_C), .SIG_TABLE(SIG_C)) dut_u (
      .clk_i(clk), .resetn_i(resetn), .porn_i(porn), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .instr_i(instr), .fuse_i(fuse),
      .eeprom_busy_i(eeprom_busy), .load_data_o(load_data), .load_special_o(load_special),
      .cpu_stall_o(cpu_stall), .flash_o(flash), .pbuf_o(pbuf));

   fsp_cpu_model cpu_u (.clk_i(clk), .cpu_stall_i(cpu_stall), .load_data_i(load_data),
      .load_special_i(load_special), .instr_o(instr));

   initial begin
      forever #10 clk = ~clk;
   end

   // ---------------------------------------------------------------------------
   // Output monitors
   // ---------------------------------------------------------------------------
   always @(posedge clk) begin
      if (pbuf.wr === 1'b1) begin
         wr_cnt    <= wr_cnt + 1;
         pbuf_seen <= pbuf;
      end
      if (pbuf.clear === 1'b1) clr_cnt <= clr_cnt + 1;
      if (cpu_stall === 1'b1) stall_cnt <= stall_cnt + 1;
      if (flash.erase === 1'b1 || flash.write === 1'b1) flash_seen <= flash;
   end

   // ---------------------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------------------
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic apb(input logic wr, input logic [9:0] addr, input logic [7:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      if (last_end == $time) @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= {24'h00_0000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) check(1'b0, "bus timeout");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      last_end = $time;
   endtask

   task automatic run_op(input logic [7:0] cmd, input logic mid_reset);
      logic [31:0] rd;
      logic        er;
      logic        sp;
      logic [7:0]  ld;
      int          s0;
      int          c0;
      int          n;
      s0 = stall_cnt;
      c0 = clr_cnt;
      apb(1'b1, CSR_A, cmd, rd, er);
      cpu_u.issue(1'b0, 16'h1200, 16'h5555, 0, sp, ld);
      apb(1'b0, CSR_A, 8'h00, rd, er);
      check(rd[7:0] === cmd, "bits during op");
      apb(1'b1, CSR_A, 8'h00, rd, er);
      apb(1'b0, CSR_A, 8'h00, rd, er);
      check(rd[7:0] === cmd, "write during op");
      if (mid_reset) begin
         resetn <= 1'b0;
         repeat (2) @(posedge clk);
         resetn <= 1'b1;
         @(posedge clk);
         check(cpu_stall === 1'b1, "op aborted by reset");
      end
      n = 0;
      while (cpu_stall !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (2) @(posedge clk);
      check(n < 300 && stall_cnt - s0 >= OP_CYC_C - RC_DIV_C, "op too short");
      check(stall_cnt - s0 <= OP_CYC_C * 45 / 37 + RC_DIV_C + 2, "op too long");
      check(flash_seen.word_addr === 15'h0900, "page address");
      check(flash_seen.write === cmd[2] && flash_seen.erase === !cmd[2], "op kind");
      if (cmd[2]) check(clr_cnt == c0 + 1, "buffer kept after write");
      apb(1'b0, CSR_A, 8'h00, rd, er);
      check(rd === 32'h0, "bits after op");
   endtask

   task automatic conclude();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      conclude();
   end

   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial begin
      logic [31:0] rd;
      logic        er;
      logic        sp;
      logic [7:0]  ld;
      int          w0;
      int          c0;
      int          s0;
      rows[0]  = '{8'h09, 16'h0000, 0, 1'b1, FUSE_C.low};
      rows[1]  = '{8'h09, 16'h0001, 0, 1'b1, FUSE_C.lock};
      rows[2]  = '{8'h09, 16'h0002, 0, 1'b1, FUSE_C.ext};
      rows[3]  = '{8'h09, 16'h0003, 0, 1'b1, FUSE_C.high};
      rows[4]  = '{8'h09, 16'h0005, 0, 1'b1, FUSE_C.lock};
      rows[5]  = '{8'h09, 16'h0004, 0, 1'b1, FUSE_C.low};
      rows[6]  = '{8'h21, 16'h0000, 0, 1'b1, SIG_C[7:0]};
      rows[7]  = '{8'h21, 16'h0001, 0, 1'b1, SIG_C[15:8]};
      rows[8]  = '{8'h21, 16'h0002, 0, 1'b1, SIG_C[23:16]};
      rows[9]  = '{8'h21, 16'h0003, 0, 1'b1, SIG_C[31:24]};
      rows[10] = '{8'h21, 16'h0007, 0, 1'b1, 8'hff};
      rows[11] = '{8'h09, 16'h0000, 4, 1'b0, 8'h00};
      rows[12] = '{8'h21, 16'h0001, 4, 1'b0, 8'h00};
      rows[13] = '{8'h01, 16'h0001, 0, 1'b0, 8'h00};
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      porn   <= 1'b1;
      @(posedge clk);
      apb(1'b0, CSR_A, 8'h00, rd, er);
      check(rd === 32'h0 && er === 1'b0, "register reset value");
      apb(1'b1, CSR_A, 8'hc0, rd, er);
      apb(1'b0, CSR_A, 8'h00, rd, er);
      check(rd === 32'h0, "reserved bits");
      apb(1'b0, 10'h000, 8'h00, rd, er);
      check(er === 1'b1 && rd === 32'h0, "unmapped address");
      foreach (rows[i]) begin
         apb(1'b1, CSR_A, rows[i].csr, rd, er);
         cpu_u.issue(1'b1, rows[i].z, 16'h0000, rows[i].dly, sp, ld);
         check(sp === rows[i].spec && (!rows[i].spec || ld === rows[i].dat), "load");
         apb(1'b0, CSR_A, 8'h00, rd, er);
         check(rd === 32'h0, "mode bits stuck");
      end
      w0 = wr_cnt;
      apb(1'b1, CSR_A, 8'h01, rd, er);
      cpu_u.issue(1'b0, 16'h0046, 16'hbeef, 0, sp, ld);
      check(wr_cnt == w0 + 1 && pbuf_seen.word_addr === 15'h0023, "buffer store");
      check(pbuf_seen.data === 16'hbeef, "buffer data");
      apb(1'b1, CSR_A, 8'h01, rd, er);
      cpu_u.issue(1'b0, 16'h0048, 16'h1234, 4, sp, ld);
      check(wr_cnt == w0 + 1, "late store taken");
      fuse.ext[0] <= 1'b1;
      apb(1'b1, CSR_A, 8'h01, rd, er);
      cpu_u.issue(1'b0, 16'h0046, 16'h0000, 0, sp, ld);
      check(wr_cnt == w0 + 1, "store without fuse permit");
      fuse <= FUSE_C;
      c0 = clr_cnt;
      apb(1'b1, CSR_A, 8'h11, rd, er);
      repeat (2) @(posedge clk);
      check(clr_cnt == c0 + 1, "buffer clear");
      s0 = stall_cnt;
      apb(1'b1, CSR_A, 8'h03, rd, er);
      cpu_u.issue(1'b0, 16'h1200, 16'h0000, 5, sp, ld);
      apb(1'b0, CSR_A, 8'h00, rd, er);
      check(stall_cnt == s0 && rd === 32'h0, "erase window");
      run_op(8'h03, 1'b0);
      run_op(8'h05, 1'b0);
      run_op(8'h03, 1'b1);
      apb(1'b1, CSR_A, 8'h09, rd, er);
      eeprom_busy <= 1'b1;
      cpu_u.issue(1'b1, 16'h0001, 16'h0000, 0, sp, ld);
      check(sp === 1'b0, "read during eeprom write");
      apb(1'b1, CSR_A, 8'h09, rd, er);
      apb(1'b0, CSR_A, 8'h00, rd, er);
      check(rd === 32'h0, "write during eeprom write");
      eeprom_busy <= 1'b0;
      conclude();
   end
endmodule // flash_selfprog_control_bench
